// ### verilog/ddc_chain.sv
// Purpose: Decimation back end: four half-band stages, gain, complex-to-real
// Assumes: Mixer samples arrive on clk_i with a one-cycle strobe
// Notes: A control write flushes the chain so stale taps never mix modes
`timescale 1ns/1ns
module ddc_chain (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mix_valid_i,
	input wire logic signed [ddc_pkg::DATA_W-1:0] mix_i_i,
	input wire logic signed [ddc_pkg::DATA_W-1:0] mix_q_i,
	output logic out_valid_o,
	output logic signed [ddc_pkg::DATA_W-1:0] out_i_o,
	output logic signed [ddc_pkg::DATA_W-1:0] out_q_o
);
	import ddc_pkg::*;

	// Register bus state
	logic [4:0] ctrl_q, ctrl_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic flush_q, flush_d;
	logic [15:0] cnt_q, cnt_d;

	logic [CTRL_LOG2_W-1:0] dec_log2;
	logic real_out, gain6;
	logic [1:0] nopt;
	logic en_first, en_second, en_third;
	logic stage_rst;

	assign dec_log2 = ctrl_q[CTRL_LOG2_LSB +: CTRL_LOG2_W];
	assign real_out = ctrl_q[CTRL_REAL_BIT];
	assign gain6 = ctrl_q[CTRL_GAIN_BIT];
	assign nopt = opt_stages(real_out, dec_log2);
	assign en_first = (nopt == 2'h3);
	assign en_second = (nopt >= 2'h2);
	assign en_third = (nopt >= 2'h1);
	assign stage_rst = rst_i | flush_q;

	always_comb begin
		ctrl_d = ctrl_q;
		flush_d = 1'b0;
		rdat_d = rdat_q;
		ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
		if (ack_d) begin
			rdat_d = 32'h0;
			if (wb_adr_i == ADR_CTRL) begin
				rdat_d[4:0] = ctrl_q;
				if (wb_we_i && wb_sel_i[0]) begin
					ctrl_d = wb_dat_i[4:0];
					flush_d = 1'b1;
				end
			end else if (wb_adr_i == ADR_STATUS) begin
				rdat_d[STAT_CNT_LSB +: 16] = cnt_q;
				rdat_d[STAT_EN_LSB +: 4] = {real_out, en_third, en_second, en_first};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RESET;
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
			flush_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
			flush_q <= flush_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// Stage taps: index 0 is the mixer, 4 is the final stage output
	logic sv [2][5];
	logic signed [DATA_W-1:0] sd [2][5];

	for (genvar p = 0; p < 2; p++) begin : g_path
		assign sv[p][0] = mix_valid_i;
		assign sd[p][0] = (p == 0) ? mix_i_i : mix_q_i;

		ddc_halfband #(.TAPS(TAPS_FIRST), .SHIFT(SHIFT_FIRST), .CENTER(CTR_FIRST),
			.COEF(COEF_FIRST)) u_first_halfband_11tap (
			.clk_i(clk_i), .rst_i(stage_rst), .bypass_i(~en_first), .nodecim_i(1'b0),
			.valid_i(sv[p][0]), .data_i(sd[p][0]),
			.valid_o(sv[p][1]), .data_o(sd[p][1]));

		ddc_halfband #(.TAPS(TAPS_SECOND), .SHIFT(SHIFT_SECOND), .CENTER(CTR_SECOND),
			.COEF(COEF_SECOND)) u_second_halfband_11tap (
			.clk_i(clk_i), .rst_i(stage_rst), .bypass_i(~en_second), .nodecim_i(1'b0),
			.valid_i(sv[p][1]), .data_i(sd[p][1]),
			.valid_o(sv[p][2]), .data_o(sd[p][2]));

		// Second feeds third feeds final, fixed wiring
		ddc_halfband #(.TAPS(TAPS_THIRD), .SHIFT(SHIFT_THIRD), .CENTER(CTR_THIRD),
			.COEF(COEF_THIRD)) u_third_halfband_19tap (
			.clk_i(clk_i), .rst_i(stage_rst), .bypass_i(~en_third), .nodecim_i(1'b0),
			.valid_i(sv[p][2]), .data_i(sd[p][2]),
			.valid_o(sv[p][3]), .data_o(sd[p][3]));

		// Bypass tied low: the final filter always runs
		ddc_halfband #(.TAPS(TAPS_FINAL), .SHIFT(SHIFT_FINAL), .CENTER(CTR_FINAL),
			.COEF(COEF_FINAL)) u_final_halfband_55tap (
			.clk_i(clk_i), .rst_i(stage_rst), .bypass_i(1'b0), .nodecim_i(real_out),
			.valid_i(sv[p][3]), .data_i(sd[p][3]),
			.valid_o(sv[p][4]), .data_o(sd[p][4]));
	end

	// Gain stage; both paths share one strobe since they run in lockstep
	logic g_v_q, g_v_d;
	logic signed [DATA_W-1:0] g_i_q, g_i_d, g_q_q, g_q_d;

	always_comb begin
		g_v_d = sv[0][4];
		g_i_d = g_i_q;
		g_q_d = g_q_q;
		if (sv[0][4]) begin
			// Doubling can clip full-scale input, hence the saturation
			g_i_d = gain6 ? sat16(ACC_W'(sd[0][4]) <<< 1) : sd[0][4];
			g_q_d = gain6 ? sat16(ACC_W'(sd[1][4]) <<< 1) : sd[1][4];
		end
	end

	always_ff @(posedge clk_i) begin
		if (stage_rst) begin
			g_v_q <= 1'b0;
			g_i_q <= 16'sh0;
			g_q_q <= 16'sh0;
		end else begin
			g_v_q <= g_v_d;
			g_i_q <= g_i_d;
			g_q_q <= g_q_d;
		end
	end

	// Quarter-rate mixer: phase sequence 1, j, -1, -j; only the real part leaves
	logic [1:0] rot_q, rot_d;
	logic o_v_q, o_v_d;
	logic signed [DATA_W-1:0] o_i_q, o_i_d, o_q_q, o_q_d;

	always_comb begin
		rot_d = rot_q;
		o_v_d = g_v_q;
		o_i_d = o_i_q;
		o_q_d = o_q_q;
		cnt_d = cnt_q;
		if (g_v_q) begin
			cnt_d = cnt_q + 16'h1;
			if (real_out) begin
				rot_d = rot_q + 2'h1;
				o_q_d = 16'sh0;
				case (rot_q)
					2'h0: o_i_d = g_i_q;
					2'h1: o_i_d = sat16(-ACC_W'(g_q_q));
					2'h2: o_i_d = sat16(-ACC_W'(g_i_q));
					default: o_i_d = g_q_q;
				endcase
			end else begin
				o_i_d = g_i_q;
				o_q_d = g_q_q;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (stage_rst) begin
			rot_q <= 2'h0;
			o_v_q <= 1'b0;
			o_i_q <= 16'sh0;
			o_q_q <= 16'sh0;
		end else begin
			rot_q <= rot_d;
			o_v_q <= o_v_d;
			o_i_q <= o_i_d;
			o_q_q <= o_q_d;
		end
		// Counter survives flushes so software sees total throughput
		if (rst_i) begin
			cnt_q <= 16'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign out_valid_o = o_v_q;
	assign out_i_o = o_i_q;
	assign out_q_o = o_q_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_final_feeds_out: assert property (sv[0][4] && !flush_q |=> ##1 out_valid_o)
		else $error("final stage output did not reach the port");
	chk_second_enable: assert property (en_second == (real_out ? dec_log2 >= 3'h2
		: dec_log2 >= 3'h3)) else $error("second stage enable decode wrong");
	chk_third_enable: assert property (en_third == (real_out ? dec_log2 >= 3'h1
		: dec_log2 >= 3'h2)) else $error("third stage enable decode wrong");
	chk_first_enable: assert property (en_first == (real_out ? dec_log2 >= 3'h3
		: dec_log2 >= 3'h4)) else $error("first stage enable decode wrong");
	chk_paths_aligned: assert property (sv[0][1] == sv[1][1] && sv[0][3] == sv[1][3]
		&& sv[0][4] == sv[1][4]) else $error("I and Q strobes diverged");
	chk_gain_double: assert property (sv[0][4] && gain6 && !flush_q
		&& sd[0][4] < 16'sh4000 && sd[0][4] >= -16'sh4000
		|=> g_i_q == $past(sd[0][4]) * 2) else $error("6 dB gain not applied");
	chk_real_no_q: assert property (out_valid_o && $past(real_out, 2)
		|-> out_q_o == 16'sh0) else $error("quadrature leaked in real mode");
	chk_rot_steps: assert property (g_v_q && real_out && !flush_q
		|=> rot_q == $past(rot_q) + 2'h1) else $error("mixer phase did not step");
	chk_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	chk_wb_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not given one cycle after request");

	cov_real_output: cover property (out_valid_o && real_out);
	cov_complex_dec16: cover property (out_valid_o && !real_out && en_first);
	cov_gain_clip: cover property (sv[0][4] && gain6 && sd[0][4] == 16'sh7fff);
	cov_ctrl_write: cover property (flush_q ##[1:200] out_valid_o);

endmodule : ddc_chain

// ### verilog/ddc_pkg.sv
// Purpose: Constants, coefficients and helpers for the half-band decimation chain
// Assumes: 16-bit two's complement I/Q samples, one clock domain
// Notes: Coefficients stored outer pair first, centre tap kept apart
package ddc_pkg;

	localparam int DATA_W = 16;
	localparam int ACC_W = 48;
	localparam int COEF_W = 22;
	localparam int NPAIR = 14;

	// Wishbone register map, byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	// Control fields
	localparam int CTRL_LOG2_LSB = 0;
	localparam int CTRL_LOG2_W = 3;
	localparam int CTRL_REAL_BIT = 3;
	localparam int CTRL_GAIN_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h01;
	// Status fields
	localparam int STAT_CNT_LSB = 0;
	localparam int STAT_EN_LSB = 16;

	// Stage geometry
	localparam int TAPS_FIRST = 11;
	localparam int TAPS_SECOND = 11;
	localparam int TAPS_THIRD = 19;
	localparam int TAPS_FINAL = 55;
	localparam int SHIFT_FIRST = 14;
	localparam int SHIFT_SECOND = 17;
	localparam int SHIFT_THIRD = 18;
	localparam int SHIFT_FINAL = 20;

	localparam logic signed [COEF_W-1:0] CTR_FIRST = 22'sh2000;
	localparam logic signed [COEF_W-1:0] CTR_SECOND = 22'sh10000;
	localparam logic signed [COEF_W-1:0] CTR_THIRD = 22'sh20000;
	localparam logic signed [COEF_W-1:0] CTR_FINAL = 22'sh80000;

	localparam logic signed [COEF_W-1:0] COEF_FIRST [NPAIR] = '{
		0: 22'sh63, 1: -22'sh328, 2: 22'sh12c5, default: 22'sh0};
	localparam logic signed [COEF_W-1:0] COEF_SECOND [NPAIR] = '{
		0: 22'sh35b, 1: -22'sh1a05, 2: 22'sh96aa, default: 22'sh0};
	localparam logic signed [COEF_W-1:0] COEF_THIRD [NPAIR] = '{
		0: 22'sha1, 1: -22'sh530, 2: 22'sh16b6, 3: -22'sh4b48, 4: 22'sh13920,
		default: 22'sh0};
	localparam logic signed [COEF_W-1:0] COEF_FINAL [NPAIR] = '{
		-22'sh18, 22'sh66, -22'sh12e, 22'sh2da, -22'sh608, 22'shb94, -22'sh14a4,
		22'sh22c7, -22'sh382f, 22'sh5870, -22'sh8a94, 22'she07c, -22'sh19be2,
		22'sh51010};

	// Saturate a wide value into the datapath word
	function automatic logic signed [DATA_W-1:0] sat16(input logic signed [ACC_W-1:0] v);
		if (v > 48'sh7fff) begin
			sat16 = 16'sh7fff;
		end else if (v < -48'sh8000) begin
			sat16 = -16'sh8000;
		end else begin
			sat16 = v[DATA_W-1:0];
		end
	endfunction : sat16

	// Number of optional stages ahead of the final one
	function automatic logic [1:0] opt_stages(input logic real_out,
			input logic [CTRL_LOG2_W-1:0] lg);
		logic [CTRL_LOG2_W-1:0] n;
		n = real_out ? lg : lg - 3'h1;
		if (!real_out && lg == 3'h0) begin
			opt_stages = 2'h0;
		end else if (n > 3'h3) begin
			opt_stages = 2'h3;
		end else begin
			opt_stages = n[1:0];
		end
	endfunction : opt_stages

endpackage : ddc_pkg

// ### verilog/ddc_halfband.sv
// Purpose: One half-band decimate-by-two FIR for one path
// Assumes: Odd-length symmetric taps, centre equals half of full scale
// Notes: Fully parallel sum, one result per output strobe
`timescale 1ns/1ns
module ddc_halfband #(
	parameter int TAPS = 11,
	parameter int SHIFT = 17,
	parameter logic signed [21:0] CENTER = 22'sh10000,
	parameter logic signed [21:0] COEF [14] = '{default: 22'sh0}
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bypass_i,
	input wire logic nodecim_i,
	input wire logic valid_i,
	input wire logic signed [ddc_pkg::DATA_W-1:0] data_i,
	output logic valid_o,
	output logic signed [ddc_pkg::DATA_W-1:0] data_o
);
	import ddc_pkg::*;

	localparam int MID = (TAPS - 1) / 2;
	localparam int PAIRS = (TAPS + 1) / 4;

	logic signed [DATA_W-1:0] line_q [TAPS];
	logic signed [DATA_W-1:0] line_d [TAPS];
	logic phase_q, phase_d;
	logic valid_q, valid_d;
	logic signed [DATA_W-1:0] data_q, data_d;

	// Odd-index zero taps are skipped entirely
	function automatic logic signed [ACC_W-1:0] fir_sum(input logic signed [DATA_W-1:0] l [TAPS]);
		logic signed [ACC_W-1:0] acc;
		acc = ACC_W'(CENTER) * ACC_W'(l[MID]);
		for (int k = 0; k < PAIRS; k++) begin
			acc = acc + ACC_W'(COEF[k]) * (ACC_W'(l[2*k]) + ACC_W'(l[TAPS-1-2*k]));
		end
		fir_sum = acc;
	endfunction : fir_sum

	// Round half up before the shift back to the data word
	function automatic logic signed [DATA_W-1:0] rescale(input logic signed [ACC_W-1:0] a);
		rescale = sat16((a + (48'sh1 <<< (SHIFT - 1))) >>> SHIFT);
	endfunction : rescale

	always_comb begin
		line_d = line_q;
		phase_d = phase_q;
		valid_d = 1'b0;
		data_d = data_q;
		if (bypass_i) begin
			valid_d = valid_i;
			data_d = data_i;
		end else if (valid_i) begin
			line_d[0] = data_i;
			for (int k = 1; k < TAPS; k++) begin
				line_d[k] = line_q[k-1];
			end
			phase_d = ~phase_q;
			// Without decimation every input yields an output
			if (phase_q || nodecim_i) begin
				valid_d = 1'b1;
				data_d = rescale(fir_sum(line_d));
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int k = 0; k < TAPS; k++) begin
				line_q[k] <= 16'sh0;
			end
			phase_q <= 1'b0;
			valid_q <= 1'b0;
			data_q <= 16'sh0;
		end else begin
			line_q <= line_d;
			phase_q <= phase_d;
			valid_q <= valid_d;
			data_q <= data_d;
		end
	end

	assign valid_o = valid_q;
	assign data_o = data_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_bypass_pass: assert property (bypass_i |=> valid_o == $past(valid_i)
		&& data_o == $past(data_i)) else $error("bypass altered the sample");
	chk_half_rate: assert property (!bypass_i && !nodecim_i && valid_i && !phase_q
		|=> !valid_o) else $error("decimating stage emitted on even input");
	chk_odd_emits: assert property (!bypass_i && valid_i && (phase_q || nodecim_i)
		|=> valid_o) else $error("stage missed its output strobe");

endmodule : ddc_halfband

// ### tb/ddc_mix_model.sv
// Purpose: Upstream mixer model feeding I/Q sample pairs to the chain
// Assumes: One strobe per sample on the chain clock
// Notes: Between strobes the data lines carry inverted junk, never a held value
`timescale 1ns/1ns
module ddc_mix_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic send_i,
	input wire logic signed [ddc_pkg::DATA_W-1:0] i_i,
	input wire logic signed [ddc_pkg::DATA_W-1:0] q_i,
	output logic valid_o,
	output logic signed [ddc_pkg::DATA_W-1:0] i_o,
	output logic signed [ddc_pkg::DATA_W-1:0] q_o
);
	import ddc_pkg::*;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			i_o <= 16'sh0;
			q_o <= 16'sh0;
		end else begin
			valid_o <= send_i;
			i_o <= send_i ? i_i : ~i_o;
			q_o <= send_i ? q_i : ~q_o;
		end
	end
endmodule : ddc_mix_model

// ### tb/testbench.sv
// Purpose: Self-checking bench for the decimation chain
// Assumes: Settled DC input gives unity gain through every enabled stage
// Notes: Random data from an xorshift source; fixed seed keeps runs repeatable
`timescale 1ns/1ns
module testbench;
	import ddc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_rdat;
	logic wb_ack;
	logic send = 1'b0;
	logic signed [DATA_W-1:0] s_i = 16'sh0;
	logic signed [DATA_W-1:0] s_q = 16'sh0;
	logic mix_valid;
	logic signed [DATA_W-1:0] mix_i;
	logic signed [DATA_W-1:0] mix_q;
	logic out_valid;
	logic signed [DATA_W-1:0] out_i;
	logic signed [DATA_W-1:0] out_q;
	int fail_count = 0;
	int tests_run = 0;
	int out_cnt = 0;
	int exp_tot = 0;
	logic [31:0] seed = 32'h00005eb7;
	logic mode_real = 1'b0;
	logic gain6 = 1'b0;
	logic chk_dc = 1'b0;
	logic chk_same = 1'b0;
	logic signed [DATA_W-1:0] dc_a = 16'sh0;
	logic signed [DATA_W-1:0] dc_b = 16'sh0;
	logic [31:0] rd;

	always #25 clk_i = ~clk_i;

	ddc_mix_model u_ddc_mix_model (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .i_i(s_i),
		.q_i(s_q), .valid_o(mix_valid), .i_o(mix_i), .q_o(mix_q));
	ddc_chain u_ddc_chain (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .mix_valid_i(mix_valid), .mix_i_i(mix_i),
		.mix_q_i(mix_q), .out_valid_o(out_valid), .out_i_o(out_i), .out_q_o(out_q));

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Stage enables as {real, third, second, first}
	function automatic logic [3:0] exp_en(input logic r, input logic [2:0] lg);
		logic [2:0] k;
		// Out-of-range ratios clamp to the deepest chain
		k = r ? ((lg > 3'h3) ? 3'h4 : lg + 3'h1) : ((lg > 3'h4) ? 3'h4 : lg);
		return {r, k >= 3'h2, k >= 3'h3, k == 3'h4};
	endfunction : exp_en

	function automatic logic signed [DATA_W-1:0] exp_dc(input logic signed [DATA_W-1:0] x,
			input logic g);
		logic signed [DATA_W+1:0] v;
		v = x;
		if (g) v = v <<< 1;
		if (v > 18'sh07fff) return 16'sh7fff;
		if (v < -18'sh08000) return -16'sh8000;
		return v[DATA_W-1:0];
	endfunction : exp_dc

	// Quarter-rate rotation restarts at the in-phase term after each flush
	function automatic logic signed [DATA_W-1:0] exp_real(input int k);
		case (k % 4)
			0: return exp_dc(dc_a, gain6);
			1: return -exp_dc(dc_b, gain6);
			2: return -exp_dc(dc_a, gain6);
			default: return exp_dc(dc_b, gain6);
		endcase
	endfunction : exp_real

	task automatic complete_run();
		$display("TB: checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic chk_val(input string what, input logic signed [DATA_W-1:0] exp,
			input logic signed [DATA_W-1:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_val

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
			input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= sel;
		wb_wdat <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 16);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (wb_ack !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED wb_ack expected 1 seen 0");
			complete_run();
		end
	endtask : wb_xfer

	task automatic set_mode(input logic r, input logic [2:0] lg, input logic g);
		logic [31:0] w;
		w = 32'(lg) | (32'(r) << CTRL_REAL_BIT) | (32'(g) << CTRL_GAIN_BIT);
		wb_xfer(1'b1, ADR_CTRL, 4'hf, w);
		mode_real = r;
		gain6 = g;
		out_cnt = 0;
		wb_xfer(1'b0, ADR_CTRL, 4'hf, 32'h0);
		chk_word("ctrl", w, rd);
		wb_xfer(1'b0, ADR_STATUS, 4'hf, 32'h0);
		w = (32'(exp_en(r, lg)) << STAT_EN_LSB) | (32'(exp_tot) & 32'h0000ffff);
		chk_word("status", w, rd);
	endtask : set_mode

	// Random runs feed equal I and Q with gaps; DC runs are checked once settled
	task automatic run(input logic r, input logic [2:0] lg, input logic g,
			input logic signed [DATA_W-1:0] a, input logic signed [DATA_W-1:0] b,
			input logic noise);
		logic [31:0] x;
		dc_a = a;
		dc_b = b;
		set_mode(r, lg, g);
		chk_same = noise;
		for (int k = 0; k < 1600; k++) begin
			x = rnd();
			if (k == 1300) chk_dc = !noise;
			@(posedge clk_i);
			send <= 1'b1;
			s_i <= noise ? x[15:0] : a;
			s_q <= noise ? x[15:0] : b;
			if (noise && x[16]) begin
				@(posedge clk_i);
				send <= 1'b0;
			end
		end
		@(posedge clk_i);
		send <= 1'b0;
		repeat (20) @(posedge clk_i);
		chk_dc = 1'b0;
		chk_same = 1'b0;
		chk_word("out_count", 32'(1600 >> lg), 32'(out_cnt));
		exp_tot += 1600 >> lg;
	endtask : run

	always @(posedge clk_i) begin
		if (out_valid === 1'b1) begin
			if (mode_real) chk_val("real_q", 16'sh0, out_q);
			if (chk_dc && mode_real) chk_val("real_i", exp_real(out_cnt), out_i);
			if (chk_dc && !mode_real) begin
				chk_val("dc_i", exp_dc(dc_a, gain6), out_i);
				chk_val("dc_q", exp_dc(dc_b, gain6), out_q);
			end
			if (chk_same) chk_val("iq_align", out_i, out_q);
			out_cnt++;
		end
	end

	initial begin
		logic [31:0] x;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_xfer(1'b0, ADR_CTRL, 4'hf, 32'h0);
		chk_word("ctrl_reset", 32'(CTRL_RESET), rd);
		wb_xfer(1'b0, ADR_STATUS, 4'hf, 32'h0);
		chk_word("status_reset", 32'h0, rd);
		wb_xfer(1'b1, 8'h08, 4'hf, 32'hffffffff);
		wb_xfer(1'b0, 8'h08, 4'hf, 32'h0);
		chk_word("unmapped", 32'h0, rd);
		wb_xfer(1'b1, ADR_CTRL, 4'he, 32'h0000001f);
		wb_xfer(1'b0, ADR_CTRL, 4'hf, 32'h0);
		chk_word("ctrl_sel", 32'(CTRL_RESET), rd);
		// Real output always takes 6 dB, complex alternates both gains
		for (int m = 0; m < 8; m++) begin
			x = rnd();
			run(m >= 4, m >= 4 ? 3'(m - 4) : 3'(m + 1), m >= 4 ? 1'b1 : m[0],
				$signed(x[15:0]) >>> 1, $signed(x[31:16]) >>> 1, 1'b0);
		end
		run(1'b0, 3'h1, 1'b1, 16'sh7530, -16'sh7530, 1'b0);
		run(1'b0, 3'h4, 1'b0, 16'sh0, 16'sh0, 1'b1);
		run(1'b0, 3'h2, 1'b1, 16'sh0, 16'sh0, 1'b1);
		set_mode(1'b0, 3'h7, 1'b0);
		set_mode(1'b1, 3'h3, 1'b1);
		complete_run();
	end
endmodule : testbench
